// ===== verif/tb_top.sv
// self-checking bench for the timer output and prescaler block
`timescale 1ns/1ps
module tb_top;
	import tmo_pkg::*;
	localparam logic [ADDR_W-1:0] A_PRE = {IDX_PRESCALE, 2'h0};
	localparam logic [ADDR_W-1:0] A_OUT = {IDX_OUT_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] A_STA = {IDX_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] A_BAD = 18'h3fd88;
	logic              mclk     = 1'b0;
	logic              rst      = 1'b1;
	logic [ADDR_W-1:0] av_addr  = '0;
	logic              av_read  = 1'b0;
	logic              av_write = 1'b0;
	logic [31:0]       av_wdata = '0;
	logic [31:0]       av_rdata;
	logic              av_wait;
	logic [2:0]        mode     = 3'h0;
	logic [1:0]        mt       = 2'h0;
	logic [1:0]        level    = 2'h0;
	logic [1:0]        pins;
	logic              out_pin, tick, e0, e1, os_st;
	logic [31:0]       q;
	int                bad_count = 0;
	int                checks_done = 0;

	always #10 mclk = ~mclk;

	tmo_pin_model pm (.i_mclk(mclk), .i_level(level), .o_pins(pins));

	tmo_timer_output uut (
		.i_mclk(mclk), .i_reset(rst), .i_ce(1'b1),
		.i_avs_address(av_addr), .i_avs_read(av_read), .i_avs_write(av_write),
		.i_avs_writedata(av_wdata), .i_avs_byteenable(4'hf),
		.o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
		.i_timer_mode_control(mode), .i_first_match(mt[0]), .i_second_match(mt[1]),
		.i_first_input_pin(pins[0]), .i_second_input_pin(pins[1]),
		.o_timer_output_pin(out_pin), .o_count_tick(tick),
		.o_in0_valid_edge(e0), .o_in1_valid_edge(e1), .o_oneshot_start(os_st)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		av_write <= wr;
		av_read  <= !wr;
		av_addr  <= a;
		av_wdata <= {24'h0, d};
		do begin
			@(posedge mclk);
			n++;
		end while (av_wait !== 1'b0 && n < 20);
		q = av_rdata;
		av_write <= 1'b0;
		av_read  <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			$display("FAIL bus expected ack seen none");
			report_and_stop();
		end
	endtask : bus

	task automatic pin_is(input logic exp);
		repeat (3) @(posedge mclk);
		chk("output pin", {31'h0, exp}, {31'h0, out_pin});
	endtask : pin_is

	task automatic hit(input logic [1:0] m);
		@(posedge mclk);
		mt <= m;
		@(posedge mclk);
		mt <= 2'h0;
	endtask : hit

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		bus(1'b0, A_PRE, 8'h0);
		chk("prescale reset", {24'h0, RST_PRESCALE}, q);
		bus(1'b0, A_OUT, 8'h0);
		chk("outctrl reset", {24'h0, RST_OUT_CTRL}, q);
		bus(1'b1, A_BAD, 8'hff);
		bus(1'b0, A_BAD, 8'h0);
		chk("unmapped", 32'h0, q);
		$display("regs done");
	endtask : t_regs

	task automatic t_gate();
		bus(1'b1, A_OUT, 8'h08);
		pin_is(1'b0);
		bus(1'b0, A_OUT, 8'h0);
		chk("set reads zero", 32'h0, q);
		bus(1'b1, A_OUT, 8'h09);
		pin_is(1'b1);
		bus(1'b1, A_OUT, 8'h01);
		pin_is(1'b1);
		bus(1'b1, A_OUT, 8'h05);
		pin_is(1'b0);
		bus(1'b0, A_OUT, 8'h0);
		chk("reset reads zero", 32'h1, q);
		$display("gate done");
	endtask : t_gate

	task automatic t_match();
		bus(1'b1, A_OUT, 8'h03);
		mode <= 3'h2;
		hit(2'h1);
		pin_is(1'b1);
		hit(2'h2);
		pin_is(1'b1);
		repeat (5) @(posedge mclk);
		chk("output holds", 32'h1, {31'h0, out_pin});
		mode <= 3'h0;
		bus(1'b1, A_OUT, 8'h13);
		mode <= 3'h2;
		hit(2'h2);
		pin_is(1'b0);
		mode <= 3'h0;
		bus(1'b1, A_OUT, 8'h01);
		hit(2'h1);
		pin_is(1'b0);
		$display("match done");
	endtask : t_match

	task automatic t_oneshot();
		bus(1'b1, A_OUT, 8'h23);
		mode <= 3'h2;
		hit(2'h1);
		pin_is(1'b0);
		bus(1'b1, A_OUT, 8'h63);
		@(posedge mclk);
		chk("oneshot start", 32'h1, {31'h0, os_st});
		hit(2'h1);
		pin_is(1'b1);
		hit(2'h1);
		pin_is(1'b1);
		bus(1'b0, A_OUT, 8'h0);
		chk("trigger clears", 32'h23, q);
		chk("oneshot enable", 32'h20, q & 32'h20);
		mode <= 3'h0;
		$display("oneshot done");
	endtask : t_oneshot

	task automatic t_clk();
		int exp [3] = '{1024, 256, 4};
		int c;
		for (int k = 0; k < 3; k++) begin
			mode <= 3'h0;
			bus(1'b1, A_PRE, 8'(k));
			mode <= 3'h2;
			repeat (8) @(posedge mclk);
			c = 0;
			repeat (1024) begin
				@(posedge mclk);
				if (tick === 1'b1)
					c++;
			end
			chk("tick count", exp[k], c);
		end
		mode <= 3'h0;
		$display("clk done");
	endtask : t_clk

	task automatic t_edge();
		logic [1:0] code [3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};
		int exp [3] = '{1, 1, 2};
		int c0, c1, ct;
		bus(1'b1, A_OUT, 8'h22);
		for (int k = 0; k < 3; k++) begin
			mode <= 3'h0;
			bus(1'b1, A_PRE, {code[k], code[k], 2'h0, CLK_PIN});
			mode <= 3'h2;
			repeat (8) @(posedge mclk);
			c0 = 0;
			c1 = 0;
			ct = 0;
			for (int n = 0; n < 30; n++) begin
				@(posedge mclk);
				level <= (n >= 5 && n < 15) ? 2'h3 : 2'h0;
				c0 += int'(e0 === 1'b1);
				c1 += int'(e1 === 1'b1);
				ct += int'(tick === 1'b1);
			end
			chk("pin0 edges", exp[k], c0);
			chk("pin1 edges", exp[k], c1);
			chk("pin ticks", exp[k], ct);
		end
		mode <= 3'h0;
		$display("edge done");
	endtask : t_edge

	task automatic t_first_edge();
		int c0, c1, co;
		level <= 2'h3;
		rst   <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk("wait after reset", 32'h1, {31'h0, av_wait});
		@(posedge mclk);
		chk("pin after reset", 32'h0, {31'h0, out_pin});
		bus(1'b0, A_STA, 8'h0);
		chk("status after reset", 32'h18, q);
		bus(1'b1, A_OUT, 8'h20);
		bus(1'b1, A_PRE, 8'h50);
		for (int k = 0; k < 2; k++) begin
			mode <= 3'h4;
			c0 = 0;
			c1 = 0;
			co = 0;
			repeat (10) begin
				@(posedge mclk);
				c0 += int'(e0 === 1'b1);
				c1 += int'(e1 === 1'b1);
				co += int'(os_st === 1'b1);
			end
			chk("start pin0 edges", 1 - k, c0);
			chk("start pin1 edges", 1 - k, c1);
			chk("pin clear arm", 1 - k, co);
			mode <= 3'h0;
			repeat (4) @(posedge mclk);
		end
		level <= 2'h0;
		$display("first edge done");
	endtask : t_first_edge

	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_regs();
		t_gate();
		t_match();
		t_oneshot();
		t_clk();
		t_edge();
		t_first_edge();
		report_and_stop();
	end
endmodule : tb_top

// ===== verif/tmo_pin_model.sv
// pin-side model: external pulse sources on both timer input pins
`timescale 1ns/1ps
module tmo_pin_model (
	input  wire logic       i_mclk,
	input  wire logic [1:0] i_level,
	output logic      [1:0] o_pins
);
	// levels move only on clock edges and the bench holds each one for
	// several cycles, so no pulse is narrower than the synchroniser needs
	always @(posedge i_mclk) begin
		o_pins <= i_level;
	end
endmodule : tmo_pin_model

// ===== verilog/tmo_pkg.sv
// package: constants and register map for the timer output and prescaler block
package tmo_pkg;

	// -------------------------------------------------------------
	// register map: printed offsets are indices, byte address is 4x
	// -------------------------------------------------------------
	localparam int          ADDR_W          = 18;
	localparam logic [15:0] IDX_PRESCALE    = 16'hff61;
	localparam logic [15:0] IDX_OUT_CTRL    = 16'hff63;
	localparam logic [15:0] IDX_STATUS      = 16'hff64;
	localparam logic [7:0]  RST_PRESCALE    = 8'h00;
	localparam logic [7:0]  RST_OUT_CTRL    = 8'h00;

	// -------------------------------------------------------------
	// output control fields
	// -------------------------------------------------------------
	localparam int BIT_GATE      = 0;
	localparam int BIT_INV1      = 1;
	localparam int BIT_FF_RESET  = 2;
	localparam int BIT_FF_SET    = 3;
	localparam int BIT_INV2      = 4;
	localparam int BIT_OS_EN     = 5;
	localparam int BIT_OS_TRIG   = 6;

	// -------------------------------------------------------------
	// prescaler and edge fields
	// -------------------------------------------------------------
	localparam int CLK_SEL_LO    = 0;
	localparam int IN0_EDGE_LO   = 4;
	localparam int IN1_EDGE_LO   = 6;

	localparam logic [1:0] CLK_FULL  = 2'h0;
	localparam logic [1:0] CLK_DIV4  = 2'h1;
	localparam logic [1:0] CLK_DIV256 = 2'h2;
	localparam logic [1:0] CLK_PIN   = 2'h3;
	localparam logic [7:0] DIV4_LAST   = 8'h03;
	localparam logic [7:0] DIV256_LAST = 8'hff;

	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// -------------------------------------------------------------
	// counter modes, upper two bits of the mode field
	// -------------------------------------------------------------
	localparam logic [1:0] MODE_STOP     = 2'h0;
	localparam logic [1:0] MODE_FREE     = 2'h1;
	localparam logic [1:0] MODE_PIN_CLR  = 2'h2;
	localparam logic [1:0] MODE_MATCH_CLR = 2'h3;

endpackage : tmo_pkg

// ===== verilog/tmo_timer_output.sv
// module: timer output flip-flop, prescaler and pin edge detection
`timescale 1ns/1ps
module tmo_timer_output
	import tmo_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_reset,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	input  wire logic [3:0]        i_avs_byteenable,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	input  wire logic [2:0]        i_timer_mode_control,
	input  wire logic              i_first_match,
	input  wire logic              i_second_match,
	input  wire logic              i_first_input_pin,
	input  wire logic              i_second_input_pin,
	output logic                   o_timer_output_pin,
	output logic                   o_count_tick,
	output logic                   o_in0_valid_edge,
	output logic                   o_in1_valid_edge,
	output logic                   o_oneshot_start
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	typedef struct packed {
		logic [7:0] prescale;
		logic       gate;
		logic       inv1;
		logic       inv2;
		logic       os_en;
		logic       out_ff;
		logic       armed;
		logic [7:0] div;
		logic       s0_a;
		logic       s0_b;
		logic       s1_a;
		logic       s1_b;
		logic       prev0;
		logic       prev1;
		logic       started;
		logic       tick;
		logic       e0;
		logic       e1;
		logic       os_start;
		logic       pin_out;
		logic       wait_n;
		logic [7:0] rdata;
	} tmo_state_s;

	tmo_state_s st_ff;
	tmo_state_s nxt_st;

	logic              running;
	logic              req;
	logic [ADDR_W-1:0] a_prescale;
	logic [ADDR_W-1:0] a_out_ctrl;
	logic [ADDR_W-1:0] a_status;
	logic              wr_prescale;
	logic              wr_out_ctrl;
	logic [7:0]        wdata;
	logic              rise0;
	logic              fall0;
	logic              rise1;
	logic              fall1;
	logic              edge0;
	logic              edge1;
	logic              trig;
	logic              do_set;
	logic              do_clr;
	logic              tog1;
	logic              tog2;
	logic [1:0]        clk_sel;
	logic [1:0]        sel0;
	logic [1:0]        sel1;

	assign a_prescale = ADDR_W'({IDX_PRESCALE, 2'b00});
	assign a_out_ctrl = ADDR_W'({IDX_OUT_CTRL, 2'b00});
	assign a_status   = ADDR_W'({IDX_STATUS, 2'b00});
	assign running    = (i_timer_mode_control[2:1] != MODE_STOP);
	assign req        = i_avs_read | i_avs_write;
	assign wdata      = i_avs_writedata[7:0];
	// write lands at the edge where waitrequest is seen low
	assign wr_prescale = i_avs_write && st_ff.wait_n && i_avs_byteenable[0]
		&& (i_avs_address == a_prescale);
	assign wr_out_ctrl = i_avs_write && st_ff.wait_n && i_avs_byteenable[0]
		&& (i_avs_address == a_out_ctrl);
	assign clk_sel = st_ff.prescale[CLK_SEL_LO +: 2];
	assign sel0    = st_ff.prescale[IN0_EDGE_LO +: 2];
	assign sel1    = st_ff.prescale[IN1_EDGE_LO +: 2];

	// -------------------------------------------------------------
	// edge detection on synchronised pins
	// -------------------------------------------------------------
	// prev starts at zero so a pin pulled high gives one rising edge at first start
	assign rise0 = st_ff.s0_b & ~st_ff.prev0;
	assign fall0 = ~st_ff.s0_b & st_ff.prev0;
	assign rise1 = st_ff.s1_b & ~st_ff.prev1;
	assign fall1 = ~st_ff.s1_b & st_ff.prev1;
	assign edge0 = running && ((sel0 == EDGE_FALL && fall0) || (sel0 == EDGE_RISE && rise0)
		|| (sel0 == EDGE_BOTH && (rise0 | fall0)));
	assign edge1 = running && ((sel1 == EDGE_FALL && fall1) || (sel1 == EDGE_RISE && rise1)
		|| (sel1 == EDGE_BOTH && (rise1 | fall1)));

	// -------------------------------------------------------------
	// output flip-flop control
	// -------------------------------------------------------------
	assign trig   = wr_out_ctrl && wdata[BIT_OS_TRIG] && st_ff.os_en && running;
	assign do_set = wr_out_ctrl && wdata[BIT_FF_SET] && !wdata[BIT_FF_RESET];
	assign do_clr = wr_out_ctrl && wdata[BIT_FF_RESET] && !wdata[BIT_FF_SET];
	// in one-shot mode matches only act between trigger and the closing first match
	assign tog1 = i_first_match && st_ff.inv1 && (!st_ff.os_en || st_ff.armed);
	assign tog2 = i_second_match && st_ff.inv2 && (!st_ff.os_en || st_ff.armed);

	always_comb begin
		nxt_st = st_ff;

		// two-flop synchronisers
		nxt_st.s0_a = i_first_input_pin;
		nxt_st.s0_b = st_ff.s0_a;
		nxt_st.s1_a = i_second_input_pin;
		nxt_st.s1_b = st_ff.s1_a;

		if (running) begin
			nxt_st.started = 1'b1;
		end
		// edge history frozen only before the very first start
		if (running || st_ff.started) begin
			nxt_st.prev0 = st_ff.s0_b;
			nxt_st.prev1 = st_ff.s1_b;
		end
		nxt_st.e0 = edge0;
		nxt_st.e1 = edge1;

		// prescaler
		if (!running) begin
			nxt_st.div  = 8'h00;
			nxt_st.tick = 1'b0;
		end else begin
			nxt_st.div = st_ff.div + 8'h01;
			case (clk_sel)
				CLK_FULL:   nxt_st.tick = 1'b1;
				CLK_DIV4:   nxt_st.tick = (st_ff.div[1:0] == DIV4_LAST[1:0]);
				CLK_DIV256: nxt_st.tick = (st_ff.div == DIV256_LAST);
				default:    nxt_st.tick = edge0;
			endcase
		end

		// register writes
		if (wr_prescale) begin
			nxt_st.prescale = wdata;
		end
		if (wr_out_ctrl) begin
			nxt_st.gate  = wdata[BIT_GATE];
			nxt_st.inv1  = wdata[BIT_INV1];
			nxt_st.inv2  = wdata[BIT_INV2];
			nxt_st.os_en = wdata[BIT_OS_EN];
		end

		// one-shot arming by software or first pin edge in pin clear-and-start
		nxt_st.os_start = 1'b0;
		if (trig || (st_ff.os_en && edge0
			&& i_timer_mode_control[2:1] == MODE_PIN_CLR)) begin
			nxt_st.armed    = 1'b1;
			nxt_st.os_start = 1'b1;
		end else if (!running || !st_ff.os_en || tog1) begin
			nxt_st.armed = 1'b0;
		end

		// output flip-flop: explicit preset wins over inversion
		if (do_set) begin
			nxt_st.out_ff = 1'b1;
		end else if (do_clr) begin
			nxt_st.out_ff = 1'b0;
		end else if (tog1 ^ tog2) begin
			nxt_st.out_ff = ~st_ff.out_ff;
		end else begin
			nxt_st.out_ff = st_ff.out_ff;
		end
		nxt_st.pin_out = nxt_st.gate & nxt_st.out_ff;

		// bus handshake: one wait cycle, then answer
		if (req && !st_ff.wait_n) begin
			nxt_st.wait_n = 1'b1;
			nxt_st.rdata  = 8'h00;
			if (i_avs_address == a_prescale) begin
				nxt_st.rdata = st_ff.prescale;
			end else if (i_avs_address == a_out_ctrl) begin
				// set, reset and trigger bits read zero
				nxt_st.rdata = {2'b00, st_ff.os_en, st_ff.inv2, 2'b00,
					st_ff.inv1, st_ff.gate};
			end else if (i_avs_address == a_status) begin
				nxt_st.rdata = {3'b000, st_ff.s1_b, st_ff.s0_b, st_ff.armed,
					st_ff.pin_out, st_ff.out_ff};
			end
		end else begin
			nxt_st.wait_n = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st_ff <= '0;
		end else if (i_ce) begin
			st_ff <= nxt_st;
		end
	end

	assign o_avs_readdata     = {24'h000000, st_ff.rdata};
	assign o_avs_waitrequest  = ~st_ff.wait_n;
	assign o_timer_output_pin = st_ff.pin_out;
	assign o_count_tick       = st_ff.tick;
	assign o_in0_valid_edge   = st_ff.e0;
	assign o_in1_valid_edge   = st_ff.e1;
	assign o_oneshot_start    = st_ff.os_start;

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	sequence s_set_write;
		i_ce && do_set;
	endsequence

	sequence s_clr_write;
		i_ce && do_clr;
	endsequence

	property p_gate_low;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && !nxt_st.gate) |=> !o_timer_output_pin;
	endproperty
	a_gate_low: assert property (p_gate_low)
		else $error("output pin high while gate is cleared");

	property p_gate_pass;
		@(posedge i_mclk) disable iff (i_reset)
		i_ce |=> (o_timer_output_pin == (st_ff.gate & st_ff.out_ff));
	endproperty
	a_gate_pass: assert property (p_gate_pass)
		else $error("output pin does not follow gated flip-flop");

	property p_first_toggle;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && i_first_match && st_ff.inv1 && !st_ff.os_en && !i_second_match
			&& !wr_out_ctrl) |=> (st_ff.out_ff != $past(st_ff.out_ff));
	endproperty
	a_first_toggle: assert property (p_first_toggle)
		else $error("first match did not invert output flip-flop");

	property p_second_toggle;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && i_second_match && st_ff.inv2 && !st_ff.os_en && !i_first_match
			&& !wr_out_ctrl) |=> (st_ff.out_ff != $past(st_ff.out_ff));
	endproperty
	a_second_toggle: assert property (p_second_toggle)
		else $error("second match did not invert output flip-flop");

	property p_preset;
		@(posedge i_mclk) disable iff (i_reset)
		(s_set_write |=> st_ff.out_ff) and (s_clr_write |=> !st_ff.out_ff);
	endproperty
	a_preset: assert property (p_preset)
		else $error("preset write did not force flip-flop");

	property p_ctrl_read_zero;
		@(posedge i_mclk) disable iff (i_reset)
		(!o_avs_waitrequest && i_avs_address == a_out_ctrl)
			|-> (o_avs_readdata[BIT_FF_SET] == 1'b0 && o_avs_readdata[BIT_FF_RESET] == 1'b0
			&& o_avs_readdata[BIT_OS_TRIG] == 1'b0);
	endproperty
	a_ctrl_read_zero: assert property (p_ctrl_read_zero)
		else $error("set, reset or trigger bit read back as one");

	property p_hold;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && !tog1 && !tog2 && !do_set && !do_clr) |=> $stable(st_ff.out_ff);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output flip-flop changed without cause");

	property p_oneshot_idle;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && st_ff.os_en && !st_ff.armed && !wr_out_ctrl) |=> $stable(st_ff.out_ff);
	endproperty
	a_oneshot_idle: assert property (p_oneshot_idle)
		else $error("unarmed one-shot inverted the flip-flop");

	property p_stopped_no_tick;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && !running) |=> (!o_count_tick && st_ff.div == 8'h00);
	endproperty
	a_stopped_no_tick: assert property (p_stopped_no_tick)
		else $error("count tick while counter is stopped");

	property p_div4;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && running && clk_sel == CLK_DIV4 && st_ff.div[1:0] == 2'h3 && !wr_prescale)
			|=> o_count_tick;
	endproperty
	a_div4: assert property (p_div4)
		else $error("divide-by-four tick missing");

	property p_first_start_edge;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && running && !st_ff.started && st_ff.s0_b && sel0 == EDGE_RISE)
			|=> o_in0_valid_edge;
	endproperty
	a_first_start_edge: assert property (p_first_start_edge)
		else $error("high pin at first start gave no rising edge");

	sequence s_trigger;
		i_ce && trig;
	endsequence

	property p_trig_arms;
		@(posedge i_mclk) disable iff (i_reset)
		s_trigger |=> (o_oneshot_start && st_ff.armed);
	endproperty
	a_trig_arms: assert property (p_trig_arms)
		else $error("software trigger did not arm the one-shot");

	property p_pin_edge_arms;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && st_ff.os_en && edge0 && i_timer_mode_control[2:1] == MODE_PIN_CLR)
			|=> (o_oneshot_start && st_ff.armed);
	endproperty
	a_pin_edge_arms: assert property (p_pin_edge_arms)
		else $error("pin edge in pin clear-and-start did not arm the one-shot");

	property p_rise_ignores_fall;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && sel0 == EDGE_RISE && fall0) |=> !o_in0_valid_edge;
	endproperty
	a_rise_ignores_fall: assert property (p_rise_ignores_fall)
		else $error("falling edge on first pin taken in rising mode");

	property p_fall_ignores_rise;
		@(posedge i_mclk) disable iff (i_reset)
		(i_ce && sel1 == EDGE_FALL && rise1) |=> !o_in1_valid_edge;
	endproperty
	a_fall_ignores_rise: assert property (p_fall_ignores_rise)
		else $error("rising edge on second pin taken in falling mode");

endmodule : tmo_timer_output
